// File: include/gate_driver_defines.svh
// Purpose: Offsets, field positions, reset values and timings of the gate driver control bank
// Assumes: 32-bit APB, one register per aligned word, byte address = 4 * index
// Notes:   Definitions only
`ifndef GATE_DRIVER_DEFINES_SVH
`define GATE_DRIVER_DEFINES_SVH

// ============================================================
// Register indices
`define IDX_PWM_CONTROL      10'h004
`define IDX_DIAG_CONFIG      10'h005
`define IDX_SRC_CURRENT_A    10'h006
`define IDX_SRC_CURRENT_B    10'h007
`define IDX_SRC_CURRENT_C    10'h008
`define IDX_DIAG_RESULT      10'h020

// ============================================================
// Reset values
`define RST_PWM_CONTROL      8'h00
`define RST_DIAG_CONFIG      8'h40
`define RST_SRC_CURRENT      8'hFF

// ============================================================
// Field positions
`define PWM_FAULT_CLEAR_BIT  7
`define PWM_MODE_MSB         6
`define PWM_MODE_LSB         4
`define PWM_BRAKE_MSB        1
`define PWM_BRAKE_LSB        0
`define DIAG_OT_MODE_BIT     7
`define DIAG_DLY_MSB         6
`define DIAG_DLY_LSB         5
`define DIAG_SHORT_EN_BIT    4
`define DIAG_STBY_OL_EN_BIT  3
`define SRC_LOW_MSB          7
`define SRC_LOW_LSB          4
`define SRC_HIGH_MSB         3
`define SRC_HIGH_LSB         0
`define RES_OPEN_LOAD_LSB    0
`define RES_SHORT_BAT_LSB    3
`define RES_SHORT_GND_LSB    6
`define RES_OT_FAULT_BIT     9
`define RES_BUSY_BIT         10

// ============================================================
// Timing: delays in ns, clock period in ns
`define CLK_PERIOD_NS        4
`define OL_DLY0_NS           250000
`define OL_DLY1_NS           1250000
`define OL_DLY2_NS           5000000
`define OL_DLY3_NS           11500000
`define SHT_DLY0_NS          100000
`define SHT_DLY1_NS          500000
`define SHT_DLY2_NS          2000000
`define SHT_DLY3_NS          4400000

`endif

// File: include/gate_driver_pkg.sv
// Purpose: Types of the gate driver control bank
// Assumes: Register constants live in gate_driver_defines.svh; PWM_MODE_SINGLE lives here
// Notes:   Source current codes name the peak current they select
package gate_driver_pkg;

  // ============================================================
  // Diagnostic sequencer states
  typedef enum logic [1:0]
  {
    ST_IDLE  = 2'b00,
    ST_SHORT = 2'b01,
    ST_OPEN  = 2'b10
  } diag_state_e;

  // ============================================================
  // Brake override codes in single-input mode
  typedef enum logic [1:0]
  {
    BRAKE_FOLLOW = 2'b00,
    BRAKE_LOW_ON = 2'b01,
    BRAKE_HIGH_ON = 2'b10,
    BRAKE_COAST  = 2'b11
  } brake_sel_e;

  // Single-input PWM mode code
  localparam logic [2:0] PWM_MODE_SINGLE = 3'h2;

  // ============================================================
  // Peak gate source current codes
  typedef enum logic [3:0]
  {
    SRC_1P5MA  = 4'h0,
    SRC_3P5MA  = 4'h1,
    SRC_5MA    = 4'h2,
    SRC_10MA   = 4'h3,
    SRC_15MA   = 4'h4,
    SRC_50MA   = 4'h5,
    SRC_60MA   = 4'h6,
    SRC_65MA   = 4'h7,
    SRC_200MA  = 4'h8,
    SRC_210MA  = 4'h9,
    SRC_260MA  = 4'hA,
    SRC_265MA  = 4'hB,
    SRC_735MA  = 4'hC,
    SRC_800MA  = 4'hD,
    SRC_935MA  = 4'hE,
    SRC_1000MA = 4'hF
  } source_current_e;

endpackage

// File: verilog/gate_driver_control_regs.sv
// Purpose: Control register bank of a three-phase gate driver, APB slave
// Assumes: Synchronous active-high reset; pins pass a two-flop synchroniser
// Notes:   One wait state on every APB access
//
// How it works
// - Brake 00b: outputs follow commanded inputs
// - In single-input mode 01b lows on, 10b highs on, 11b coast
// - Diag config at 0x05, reset 0x40, layout
// - Overtemp mode 0: latched fault persists
// - Overtemp mode 1: automatic recovery
// - Delay 00b: open-load 0.25ms, short 0.1ms
// - Delay 01b: open-load 1.25ms, short 0.5ms
// - Delay 10b default: 5ms and 2ms
// - Delay 11b: open-load 11.5ms, short 4.4ms
// - Short enable runs offline supply/ground short tests
// - Standby open-load enable starts standby test
// - Standby open-load enable self-clears when done
// - Bits 2..0 enable active open-load C,B,A
// - Phase A current register 0x06, reset 0xFF
// - Phase B current register 0x07, reset 0xFF
// - Phase C current register 0x08, reset 0xFF
// - Codes 0-7: 1.5 to 65 mA
// - Codes 8-15: 200 to 1000 mA
// - Fault clear clears latches, self-clears
// - Control registers read back last write, except the two self-clearing bits
`timescale 1ns/1ps
`include "gate_driver_defines.svh"

module gate_driver_control_regs
  import gate_driver_pkg::*;
#(
  parameter int unsigned OL_DLY0_CYC  = `OL_DLY0_NS / `CLK_PERIOD_NS,
  parameter int unsigned OL_DLY1_CYC  = `OL_DLY1_NS / `CLK_PERIOD_NS,
  parameter int unsigned OL_DLY2_CYC  = `OL_DLY2_NS / `CLK_PERIOD_NS,
  parameter int unsigned OL_DLY3_CYC  = `OL_DLY3_NS / `CLK_PERIOD_NS,
  parameter int unsigned SHT_DLY0_CYC = `SHT_DLY0_NS / `CLK_PERIOD_NS,
  parameter int unsigned SHT_DLY1_CYC = `SHT_DLY1_NS / `CLK_PERIOD_NS,
  parameter int unsigned SHT_DLY2_CYC = `SHT_DLY2_NS / `CLK_PERIOD_NS,
  parameter int unsigned SHT_DLY3_CYC = `SHT_DLY3_NS / `CLK_PERIOD_NS
)
(
  input  wire logic        i_clk_sys,
  input  wire logic        i_reset,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [2:0]  i_pwm_high,
  input  wire logic [2:0]  i_pwm_low,
  input  wire logic        i_overtemp,
  input  wire logic        i_standby,
  input  wire logic [2:0]  i_open_load_sense,
  input  wire logic [2:0]  i_short_bat_sense,
  input  wire logic [2:0]  i_short_gnd_sense,
  output logic      [2:0]  o_gate_high,
  output logic      [2:0]  o_gate_low,
  output logic      [3:0]  o_src_current_high_a,
  output logic      [3:0]  o_src_current_high_b,
  output logic      [3:0]  o_src_current_high_c,
  output logic      [3:0]  o_src_current_low_a,
  output logic      [3:0]  o_src_current_low_b,
  output logic      [3:0]  o_src_current_low_c,
  output logic             o_overtemp_fault
);

  localparam int CNT_W   = 22;
  localparam int SYNC_W  = 17;
  localparam int DLY_MAX = int'(32'h1 << CNT_W);

  // Elaboration check: every delay fits the counter and lasts at least one cycle
  if (OL_DLY0_CYC == 0 || OL_DLY1_CYC == 0 || OL_DLY2_CYC == 0 || OL_DLY3_CYC == 0 ||
      SHT_DLY0_CYC == 0 || SHT_DLY1_CYC == 0 || SHT_DLY2_CYC == 0 || SHT_DLY3_CYC == 0 ||
      OL_DLY0_CYC >= DLY_MAX || OL_DLY1_CYC >= DLY_MAX || OL_DLY2_CYC >= DLY_MAX || OL_DLY3_CYC >= DLY_MAX ||
      SHT_DLY0_CYC >= DLY_MAX || SHT_DLY1_CYC >= DLY_MAX || SHT_DLY2_CYC >= DLY_MAX || SHT_DLY3_CYC >= DLY_MAX)
  begin
    $error("delay parameters out of range");
  end

  // ============================================================
  // Delay selection
  function automatic logic [CNT_W-1:0] ol_cycles(input logic [1:0] sel);
    unique case (sel)
      2'h0: ol_cycles = CNT_W'(OL_DLY0_CYC);
      2'h1: ol_cycles = CNT_W'(OL_DLY1_CYC);
      2'h2: ol_cycles = CNT_W'(OL_DLY2_CYC);
      2'h3: ol_cycles = CNT_W'(OL_DLY3_CYC);
    endcase
  endfunction

  function automatic logic [CNT_W-1:0] sht_cycles(input logic [1:0] sel);
    unique case (sel)
      2'h0: sht_cycles = CNT_W'(SHT_DLY0_CYC);
      2'h1: sht_cycles = CNT_W'(SHT_DLY1_CYC);
      2'h2: sht_cycles = CNT_W'(SHT_DLY2_CYC);
      2'h3: sht_cycles = CNT_W'(SHT_DLY3_CYC);
    endcase
  endfunction

  // ============================================================
  // Pin synchroniser
  logic [SYNC_W-1:0] sync1_q;
  logic [SYNC_W-1:0] sync2_q;
  logic [SYNC_W-1:0] sync1_d;
  logic [SYNC_W-1:0] sync2_d;

  // First stage feeds only the second stage
  always_comb
  begin
    sync1_d = {i_pwm_high, i_pwm_low, i_overtemp, i_standby,
               i_open_load_sense, i_short_bat_sense, i_short_gnd_sense};
    sync2_d = sync1_q;
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      sync1_q <= '0;
      sync2_q <= '0;
    end
    else
    begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
    end
  end

  logic [2:0] s_pwm_high;
  logic [2:0] s_pwm_low;
  logic       s_overtemp;
  logic       s_standby;
  logic [2:0] s_open_load;
  logic [2:0] s_short_bat;
  logic [2:0] s_short_gnd;

  // Synchronised pin fields
  assign {s_pwm_high, s_pwm_low, s_overtemp, s_standby,
          s_open_load, s_short_bat, s_short_gnd} = sync2_q;

  // ============================================================
  // Bus, registers and diagnostics
  logic [7:0]       pwm_ctrl_q;
  logic [7:0]       pwm_ctrl_d;
  logic [7:0]       diag_cfg_q;
  logic [7:0]       diag_cfg_d;
  logic [7:0]       src_cur_q [3];
  logic [7:0]       src_cur_d [3];
  logic [2:0]       ol_flag_q;
  logic [2:0]       ol_flag_d;
  logic [2:0]       bat_flag_q;
  logic [2:0]       bat_flag_d;
  logic [2:0]       gnd_flag_q;
  logic [2:0]       gnd_flag_d;
  logic             ot_fault_q;
  logic             ot_fault_d;
  logic             short_done_q;
  logic             short_done_d;
  diag_state_e      state_q;
  diag_state_e      state_d;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic             pready_q;
  logic             pready_d;
  logic             pslverr_q;
  logic             pslverr_d;
  logic [31:0]      prdata_q;
  logic [31:0]      prdata_d;

  logic [9:0]  idx;
  logic        mapped;
  logic        wr_fire;
  logic        clr;
  logic [31:0] rd_val;

  // Decode, write, diagnostic sequencing and read mux
  always_comb
  begin
    idx        = paddr[11:2];
    mapped     = idx inside {`IDX_PWM_CONTROL, `IDX_DIAG_CONFIG, `IDX_SRC_CURRENT_A,
                             `IDX_SRC_CURRENT_B, `IDX_SRC_CURRENT_C, `IDX_DIAG_RESULT};
    wr_fire    = psel && penable && pready_q && pwrite && mapped;
    clr        = 1'b0;
    pwm_ctrl_d = pwm_ctrl_q;
    diag_cfg_d = diag_cfg_q;
    src_cur_d  = src_cur_q;

    // Software writes; the result register is read-only
    if (wr_fire)
    begin
      unique case (idx)
        `IDX_PWM_CONTROL:
        begin
          pwm_ctrl_d = pwdata[7:0];
          pwm_ctrl_d[`PWM_FAULT_CLEAR_BIT] = 1'b0;
          clr = pwdata[`PWM_FAULT_CLEAR_BIT];
        end
        `IDX_DIAG_CONFIG:   diag_cfg_d   = pwdata[7:0];
        `IDX_SRC_CURRENT_A: src_cur_d[0] = pwdata[7:0];
        `IDX_SRC_CURRENT_B: src_cur_d[1] = pwdata[7:0];
        `IDX_SRC_CURRENT_C: src_cur_d[2] = pwdata[7:0];
        default: ;
      endcase
    end

    // Latched flags: a new event beats a clear in the same cycle
    bat_flag_d = bat_flag_q & ~{3{clr}};
    gnd_flag_d = gnd_flag_q & ~{3{clr}};
    ol_flag_d  = ol_flag_q & ~{3{clr}};
    ot_fault_d = diag_cfg_q[`DIAG_OT_MODE_BIT] ? s_overtemp
                                               : ((ot_fault_q & ~clr) | s_overtemp);

    // Active open-load checks per phase while running
    ol_flag_d = ol_flag_d | (diag_cfg_q[2:0] & s_open_load & {3{~s_standby}});

    // Offline tests only run in standby; leaving standby aborts them
    state_d      = state_q;
    cnt_d        = cnt_q + CNT_W'(1);
    short_done_d = short_done_q & s_standby;
    unique case (state_q)
      ST_IDLE:
      begin
        cnt_d = '0;
        if (s_standby && diag_cfg_q[`DIAG_SHORT_EN_BIT] && !short_done_q)
          state_d = ST_SHORT;
        else if (s_standby && diag_cfg_q[`DIAG_STBY_OL_EN_BIT])
          state_d = ST_OPEN;
      end
      ST_SHORT:
      begin
        if (!s_standby)
          state_d = ST_IDLE;
        else if (cnt_q == sht_cycles(diag_cfg_q[`DIAG_DLY_MSB:`DIAG_DLY_LSB]) - CNT_W'(1))
        begin
          bat_flag_d   = bat_flag_d | s_short_bat;
          gnd_flag_d   = gnd_flag_d | s_short_gnd;
          short_done_d = 1'b1;
          state_d      = ST_IDLE;
        end
      end
      ST_OPEN:
      begin
        if (!s_standby)
          state_d = ST_IDLE;
        else if (cnt_q == ol_cycles(diag_cfg_q[`DIAG_DLY_MSB:`DIAG_DLY_LSB]) - CNT_W'(1))
        begin
          ol_flag_d = ol_flag_d | s_open_load;
          diag_cfg_d[`DIAG_STBY_OL_EN_BIT] = 1'b0;
          state_d   = ST_IDLE;
        end
      end
      default: state_d = ST_IDLE;
    endcase

    // Read mux, unused bits read as zero
    rd_val = '0;
    unique case (idx)
      `IDX_PWM_CONTROL:   rd_val[7:0] = pwm_ctrl_q;
      `IDX_DIAG_CONFIG:   rd_val[7:0] = diag_cfg_q;
      `IDX_SRC_CURRENT_A: rd_val[7:0] = src_cur_q[0];
      `IDX_SRC_CURRENT_B: rd_val[7:0] = src_cur_q[1];
      `IDX_SRC_CURRENT_C: rd_val[7:0] = src_cur_q[2];
      `IDX_DIAG_RESULT:
      begin
        rd_val[`RES_OPEN_LOAD_LSB +: 3] = ol_flag_q;
        rd_val[`RES_SHORT_BAT_LSB +: 3] = bat_flag_q;
        rd_val[`RES_SHORT_GND_LSB +: 3] = gnd_flag_q;
        rd_val[`RES_OT_FAULT_BIT]       = ot_fault_q;
        rd_val[`RES_BUSY_BIT]           = (state_q != ST_IDLE);
      end
      default: rd_val = '0;
    endcase

    // One wait state keeps pready and prdata registered
    pready_d  = psel && penable && !pready_q;
    pslverr_d = pready_d && !mapped;
    prdata_d  = (pready_d && !pwrite && mapped) ? rd_val : 32'h0000_0000;
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      pwm_ctrl_q   <= `RST_PWM_CONTROL;
      diag_cfg_q   <= `RST_DIAG_CONFIG;
      src_cur_q    <= '{default: `RST_SRC_CURRENT};
      ol_flag_q    <= '0;
      bat_flag_q   <= '0;
      gnd_flag_q   <= '0;
      ot_fault_q   <= 1'b0;
      short_done_q <= 1'b0;
      state_q      <= ST_IDLE;
      cnt_q        <= '0;
      pready_q     <= 1'b0;
      pslverr_q    <= 1'b0;
      prdata_q     <= '0;
    end
    else
    begin
      pwm_ctrl_q   <= pwm_ctrl_d;
      diag_cfg_q   <= diag_cfg_d;
      src_cur_q    <= src_cur_d;
      ol_flag_q    <= ol_flag_d;
      bat_flag_q   <= bat_flag_d;
      gnd_flag_q   <= gnd_flag_d;
      ot_fault_q   <= ot_fault_d;
      short_done_q <= short_done_d;
      state_q      <= state_d;
      cnt_q        <= cnt_d;
      pready_q     <= pready_d;
      pslverr_q    <= pslverr_d;
      prdata_q     <= prdata_d;
    end
  end

  // ============================================================
  // Gate outputs and applied source current
  logic            gate_high_q [3];
  logic            gate_high_d [3];
  logic            gate_low_q  [3];
  logic            gate_low_d  [3];
  source_current_e cur_high_q  [3];
  source_current_e cur_high_d  [3];
  source_current_e cur_low_q   [3];
  source_current_e cur_low_d   [3];
  brake_sel_e      brake;

  // Overtemperature forces coast ahead of any command
  always_comb
  begin
    brake = brake_sel_e'(pwm_ctrl_q[`PWM_BRAKE_MSB:`PWM_BRAKE_LSB]);
    for (int i = 0; i < 3; i++)
    begin
      gate_high_d[i] = s_pwm_high[i];
      gate_low_d[i]  = s_pwm_low[i];
      if (pwm_ctrl_q[`PWM_MODE_MSB:`PWM_MODE_LSB] == PWM_MODE_SINGLE)
      begin
        unique case (brake)
          BRAKE_FOLLOW:  ;
          BRAKE_LOW_ON:  {gate_high_d[i], gate_low_d[i]} = 2'h1;
          BRAKE_HIGH_ON: {gate_high_d[i], gate_low_d[i]} = 2'h2;
          BRAKE_COAST:   {gate_high_d[i], gate_low_d[i]} = 2'h0;
        endcase
      end
      if (ot_fault_q) {gate_high_d[i], gate_low_d[i]} = 2'h0;
      // Code is latched only on a switch edge, so a transition in flight keeps its current
      cur_high_d[i] = cur_high_q[i];
      cur_low_d[i]  = cur_low_q[i];
      if (gate_high_d[i] != gate_high_q[i])
        cur_high_d[i] = source_current_e'(src_cur_q[i][`SRC_HIGH_MSB:`SRC_HIGH_LSB]);
      if (gate_low_d[i] != gate_low_q[i])
        cur_low_d[i] = source_current_e'(src_cur_q[i][`SRC_LOW_MSB:`SRC_LOW_LSB]);
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      gate_high_q <= '{default: 1'b0};
      gate_low_q  <= '{default: 1'b0};
      cur_high_q  <= '{default: SRC_1000MA};
      cur_low_q   <= '{default: SRC_1000MA};
    end
    else
    begin
      gate_high_q <= gate_high_d;
      gate_low_q  <= gate_low_d;
      cur_high_q  <= cur_high_d;
      cur_low_q   <= cur_low_d;
    end
  end

  // ============================================================
  // Outputs, all straight from flops
  assign prdata               = prdata_q;
  assign pready               = pready_q;
  assign pslverr              = pslverr_q;
  assign o_gate_high          = {gate_high_q[2], gate_high_q[1], gate_high_q[0]};
  assign o_gate_low           = {gate_low_q[2], gate_low_q[1], gate_low_q[0]};
  assign o_src_current_high_a = cur_high_q[0];
  assign o_src_current_high_b = cur_high_q[1];
  assign o_src_current_high_c = cur_high_q[2];
  assign o_src_current_low_a  = cur_low_q[0];
  assign o_src_current_low_b  = cur_low_q[1];
  assign o_src_current_low_c  = cur_low_q[2];
  assign o_overtemp_fault     = ot_fault_q;

endmodule

// File: test/gate_driver_control_regs_props.sv
// Purpose: Bus and gate output properties of the control bank
// Assumes: One clock, synchronous active-high reset
// Notes:   Bound to the design top after the module
`timescale 1ns/1ps
`include "gate_driver_defines.svh"
module gate_driver_control_regs_props (
  input wire logic        i_clk_sys,
  input wire logic        i_reset,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        i_overtemp,
  input wire logic [2:0]  o_gate_high,
  input wire logic [2:0]  o_gate_low,
  input wire logic [3:0]  o_src_current_high_a,
  input wire logic [3:0]  o_src_current_low_a,
  input wire logic        o_overtemp_fault
);
  // ========
  // Decode of mapped words
  logic hit;
  assign hit = (paddr[11:2] >= `IDX_PWM_CONTROL && paddr[11:2] <= `IDX_SRC_CURRENT_C)
    || paddr[11:2] == `IDX_DIAG_RESULT;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);

  // ========
  // Bus timing and answers
  property p_ready_pulse; pready |=> !pready; endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready held too long");
  property p_one_wait; $rose(penable) && psel |-> !pready ##1 pready; endproperty
  a_one_wait: assert property (p_one_wait) else $error("wait state count wrong");
  property p_err_ready; pslverr |-> pready && prdata == 32'h0; endproperty
  a_err_ready: assert property (p_err_ready) else $error("error without ready");
  property p_idle_data; !pready |-> prdata == 32'h0; endproperty
  a_idle_data: assert property (p_idle_data) else $error("read data outside answer");
  property p_unmapped; pready && !hit |-> pslverr; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped word accepted");
  property p_mapped; pready && hit |-> !pslverr; endproperty
  a_mapped: assert property (p_mapped) else $error("mapped word refused");
  // ========
  // Fault and current code relations
  property p_fault_off; o_overtemp_fault && $past(o_overtemp_fault) |-> {o_gate_high, o_gate_low} == 6'h00;
  endproperty
  a_fault_off: assert property (p_fault_off) else $error("gate on during fault");
  property p_fault_cause; $rose(o_overtemp_fault) |-> $past(i_overtemp, 2) || $past(i_overtemp, 3);
  endproperty
  a_fault_cause: assert property (p_fault_cause) else $error("fault without cause");
  property p_hold_high; $stable(o_gate_high[0]) |-> $stable(o_src_current_high_a); endproperty
  a_hold_high: assert property (p_hold_high) else $error("high code moved mid phase");
  property p_hold_low; $stable(o_gate_low[0]) |-> $stable(o_src_current_low_a); endproperty
  a_hold_low: assert property (p_hold_low) else $error("low code moved mid phase");
  c_refused: cover property (pslverr);
  c_fault: cover property ($rose(o_overtemp_fault));
  c_brake_low: cover property (o_gate_low == 3'h7 && o_gate_high == 3'h0);
endmodule

bind gate_driver_control_regs gate_driver_control_regs_props u_props (
  .i_clk_sys(i_clk_sys), .i_reset(i_reset), .psel(psel), .penable(penable),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .i_overtemp(i_overtemp), .o_gate_high(o_gate_high), .o_gate_low(o_gate_low),
  .o_src_current_high_a(o_src_current_high_a), .o_src_current_low_a(o_src_current_low_a),
  .o_overtemp_fault(o_overtemp_fault)
);

// File: test/gate_driver_control_regs_bench.sv
// Purpose: Self-checking bench of the control bank
// Assumes: Short diagnostic delays set by parameter
// Notes:   Register model kept in an int array
`timescale 1ns/1ps
module gate_driver_control_regs_bench;
  localparam int SH [4] = '{4, 5, 6, 7};
  localparam int OL [4] = '{8, 10, 12, 14};
  localparam logic [5:0] BX [4] = '{6'h2A, 6'h07, 6'h38, 6'h00};
  logic        i_clk_sys, i_reset, psel, penable, pwrite, pready, pslverr;
  logic        i_overtemp, i_standby, flt, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0]  hi, lo, ol, sb, sg, gh, gl;
  logic [3:0]  sha, shb, shc, sla, slb, slc;
  logic [15:0] lfsr_q;
  logic [11:0] ph;
  int          num_errors, num_checks;
  int          mdl [int];

  gate_driver_control_regs #(.OL_DLY0_CYC(OL[0]), .OL_DLY1_CYC(OL[1]), .OL_DLY2_CYC(OL[2]),
    .OL_DLY3_CYC(OL[3]), .SHT_DLY0_CYC(SH[0]), .SHT_DLY1_CYC(SH[1]), .SHT_DLY2_CYC(SH[2]),
    .SHT_DLY3_CYC(SH[3])) uut (
    .i_clk_sys(i_clk_sys), .i_reset(i_reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .i_pwm_high(hi), .i_pwm_low(lo), .i_overtemp(i_overtemp), .i_standby(i_standby),
    .i_open_load_sense(ol), .i_short_bat_sense(sb), .i_short_gnd_sense(sg),
    .o_gate_high(gh), .o_gate_low(gl), .o_src_current_high_a(sha), .o_src_current_high_b(shb),
    .o_src_current_high_c(shc), .o_src_current_low_a(sla), .o_src_current_low_b(slb),
    .o_src_current_low_c(slc), .o_overtemp_fault(flt));

  // ========
  // Clock and watchdog; the limit is well above the planned run
  initial
  begin
    i_clk_sys = 1'b0;
    forever #2 i_clk_sys = ~i_clk_sys;
  end
  initial
  begin
    repeat (20000) @(posedge i_clk_sys);
    num_errors++;
    stop_test;
  end

  function automatic logic [15:0] nxt(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction

  task automatic stop_test;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk_sys);
  endtask

  // ========
  // Bus master; a gap edge before each setup avoids double assignment
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clk_sys);
    penable <= 1'b1;
    do
    begin
      @(posedge i_clk_sys);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 16)
      chk(32'h0, 32'h1, "no ready");
  endtask

  task automatic wr(input int idx, input logic [7:0] d);
    apb(12'(idx * 4), 1'b1, {24'h0, d});
    chk({31'h0, er}, 32'h0, "write refused");
    mdl[idx] = (idx == 4) ? int'(d & 8'h7F) : int'(d);
  endtask

  task automatic rdc(input int idx, input logic [31:0] exp, input string what);
    apb(12'(idx * 4), 1'b0, 32'h0);
    chk({31'h0, er}, 32'h0, "read refused");
    chk(rd, exp, what);
  endtask

  task automatic end_test(input string s);
    $display("test %s done", s);
  endtask

  // ========
  // Main sequence
  initial
  begin
    i_reset = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {hi, lo, ol, sb, sg, i_overtemp, i_standby} = '0;
    num_errors = 0;
    num_checks = 0;
    lfsr_q = 16'h475E;
    mdl[4] = 8'h00;
    mdl[5] = 8'h40;
    mdl[6] = 8'hFF;
    mdl[7] = 8'hFF;
    mdl[8] = 8'hFF;
    cyc(6);
    i_reset <= 1'b0;
    for (int i = 4; i <= 8; i++) rdc(i, mdl[i], "reset value");
    apb(12'h00C, 1'b0, 32'h0);
    chk({31'h0, er}, 32'h1, "unmapped refused");
    chk(rd, 32'h0, "unmapped read");
    apb(12'h080, 1'b1, 32'h7FF);
    chk({31'h0, er}, 32'h0, "result write");
    rdc(32, 32'h0, "result after write");
    end_test("registers");
    for (int k = 0; k < 16; k++)
    begin
      lfsr_q = nxt(lfsr_q);
      ph = {mdl[6][3:0], mdl[7][3:0], mdl[8][3:0]};
      wr(6, {4'(k), lfsr_q[3:0]});
      wr(7, lfsr_q[11:4]);
      wr(8, {lfsr_q[15:12], ~4'(k)});
      rdc(6, mdl[6], "current readback");
      chk({sha, shb, shc}, ph, "code held");
      hi <= 3'h7;
      lo <= 3'h0;
      cyc(5);
      chk({gh, gl}, 6'h38, "follow high");
      chk({sha, shb, shc}, {mdl[6][3:0], mdl[7][3:0], mdl[8][3:0]}, "high code");
      hi <= 3'h0;
      lo <= 3'h7;
      cyc(5);
      chk({sla, slb, slc}, {mdl[6][7:4], mdl[7][7:4], mdl[8][7:4]}, "low code");
    end
    end_test("currents");
    hi <= 3'h5;
    lo <= 3'h2;
    cyc(5);
    for (int b = 0; b < 4; b++)
    begin
      wr(4, 8'h20 | 8'(b));
      cyc(2);
      chk({gh, gl}, BX[b], "brake");
    end
    wr(4, 8'h01);
    cyc(2);
    chk({gh, gl}, 6'h2A, "brake outside single");
    wr(4, 8'h81);
    rdc(4, mdl[4], "clear reads zero");
    end_test("brake");
    i_overtemp <= 1'b1;
    cyc(6);
    chk({flt, gh, gl}, 7'h40, "fault set");
    i_overtemp <= 1'b0;
    cyc(6);
    chk(flt, 1'b1, "fault latched");
    wr(4, 8'h80);
    cyc(2);
    chk({flt, gh, gl}, 7'h2A, "fault cleared");
    wr(5, 8'hC0);
    i_overtemp <= 1'b1;
    cyc(6);
    chk(flt, 1'b1, "auto fault");
    i_overtemp <= 1'b0;
    cyc(6);
    chk(flt, 1'b0, "auto recovery");
    end_test("overtemp");
    sb <= 3'h1;
    sg <= 3'h2;
    ol <= 3'h4;
    for (int d = 0; d < 4; d++)
    begin
      wr(5, 8'h18 | 8'(d << 5));
      i_standby <= 1'b1;
      // Read lands in the last open-load cycle, so a short delay shows
      cyc(SH[d] + OL[d] + 1);
      apb(12'h080, 1'b0, 32'h0);
      chk(rd[10], 1'b1, "busy");
      rdc(32, 32'h08C, "diag flags");
      mdl[5] = mdl[5] & 8'hF7;
      rdc(5, mdl[5], "standby enable cleared");
      i_standby <= 1'b0;
      wr(4, 8'h80);
      cyc(4);
    end
    wr(5, 8'h45);
    ol <= 3'h7;
    cyc(6);
    rdc(32, 32'h005, "active open load");
    rdc(5, mdl[5], "diag readback");
    end_test("diagnostics");
    stop_test;
  end
endmodule
